/* File: logic/pfgh_function_select.sv */
// Port F/G/H pin function select registers with AHB-Lite slave and per-pin decode
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps

//
// Contract
// - Three 16-bit control registers, every bit readable and writable.
// - Port F power-on value AAAA with emulator select high, 00AA low.
// - Port G power-on value AAAA with emulator select high, A200 low.
// - Port H power-on value AAAA with emulator select high, 8AAA low.
// - Manual reset and standby leave all three registers unchanged.
// - Pin n mode field sits at bits 2n+1 and 2n.
// - Port F: 00 alternate, 01 reserved, 10 pull-up input, 11 plain input.
// - Port G pins 0-3,5: code 00 is alternate only with emulator select low.
// - Port G pins 4,6 alternate on 00; pin 7 reserved on 00.
// - Port H pin 7: 00 alternate, 01 output, 10 pull-up input, 11 input.
// - Port H pins 0-6 reserve 01; pin 6 depends on emulator select.
module pfgh_function_select (
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_manual_reset,
  input wire logic i_standby,
  // Emulator select pin
  input wire logic i_emulator_select_input,
  // AHB-Lite slave
  input wire pfgh_pkg::pfgh_ahb_req_t i_ahb,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Per-pin controls, index 8*port+pin with F=0, G=1, H=2
  output logic [23:0] o_alt_sel,
  output logic [23:0] o_out_en,
  output logic [23:0] o_in_sel,
  output logic [23:0] o_pullup_en,
  output logic [23:0] o_reserved_sel
);
  import pfgh_pkg::*;

  typedef struct packed {
    logic [15:0] f_sel;
    logic [15:0] g_sel;
    logic [15:0] h_sel;
    logic emu_lat;
    logic por_pend;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
  } pfgh_state_t;

  pfgh_state_t state_reg, state_next;
  logic emu_sync;
  logic addr_phase;
  logic [15:0] wdata16;
  logic [1:0] kind [0:23];
  logic [47:0] all_sel;

  // Pin from outside the clock domain passes two flops first
  pfgh_sync u_emu_sync (
    .i_core_clk(i_core_clk),
    .i_reset(1'b0),
    .i_ce(i_ce),
    .i_async(i_emulator_select_input),
    .o_sync(emu_sync)
  );

  assign addr_phase = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
  assign wdata16 = i_ahb.hwdata[15:0];

  // i_reset is the power-on reset; manual reset and standby are not reset inputs here
  always_comb begin
    state_next = state_reg;
    if (i_ce) begin
      state_next.wr_pend = 1'b0;
      // Data phase of a write: update the addressed register
      if (state_reg.wr_pend) begin
        if (state_reg.wr_addr == PFGH_OFF_F) begin
          state_next.f_sel = wdata16;
        end else if (state_reg.wr_addr == PFGH_OFF_G) begin
          state_next.g_sel = wdata16;
        end else if (state_reg.wr_addr == PFGH_OFF_H) begin
          state_next.h_sel = wdata16;
        end
      end
      // Address phase: latch writes, register read data
      if (addr_phase) begin
        state_next.wr_pend = i_ahb.hwrite;
        state_next.wr_addr = {i_ahb.haddr[11:2], 2'b00};
        if (!i_ahb.hwrite) begin
          if ({i_ahb.haddr[11:2], 2'b00} == PFGH_OFF_F) begin
            state_next.rdata = {16'h0000, state_next.f_sel};
          end else if ({i_ahb.haddr[11:2], 2'b00} == PFGH_OFF_G) begin
            state_next.rdata = {16'h0000, state_next.g_sel};
          end else if ({i_ahb.haddr[11:2], 2'b00} == PFGH_OFF_H) begin
            state_next.rdata = {16'h0000, state_next.h_sel};
          end else begin
            state_next.rdata = 32'h00000000; // Unmapped reads as zero
          end
        end
      end
      // Load reset values from the synchronised strap on the first enabled edge after release
      if (state_reg.por_pend) begin
        state_next.por_pend = 1'b0;
        state_next.emu_lat = emu_sync;
        state_next.f_sel = emu_sync ? PFGH_RST_EMU : PFGH_RST_F_LO;
        state_next.g_sel = emu_sync ? PFGH_RST_EMU : PFGH_RST_G_LO;
        state_next.h_sel = emu_sync ? PFGH_RST_EMU : PFGH_RST_H_LO;
      end
    end
  end

  // Only the power-on reset touches the registers; manual reset and standby do not
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg.f_sel <= PFGH_RST_EMU;
      state_reg.g_sel <= PFGH_RST_EMU;
      state_reg.h_sel <= PFGH_RST_EMU;
      state_reg.emu_lat <= 1'b1;
      state_reg.por_pend <= 1'b1;
      state_reg.wr_pend <= 1'b0;
      state_reg.wr_addr <= 12'h000;
      state_reg.rdata <= 32'h00000000;
    end else begin
      state_reg <= state_next;
    end
  end

  // Zero-wait slave, always OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = state_reg.rdata;

  // Pin kinds per port; pin 6 of port H and G pins 0-3,5 follow emulator select
  always_comb begin
    for (int p = 0; p < 24; p++) begin
      kind[p] = PFGH_KIND_PLAIN;
    end
    for (int p = 8; p < 12; p++) begin
      kind[p] = PFGH_KIND_EMU;
    end
    kind[13] = PFGH_KIND_EMU;
    kind[15] = PFGH_KIND_NOALT;
    kind[22] = PFGH_KIND_EMU;
    kind[23] = PFGH_KIND_OUT;
  end

  assign all_sel = {state_reg.h_sel, state_reg.g_sel, state_reg.f_sel};

  // One decoder per pin, field at bits 2n+1:2n; outputs follow the register
  for (genvar p = 0; p < 24; p++) begin : g_pin
    pfgh_pin_ctl_t ctl;
    pfgh_pin_decode u_dec (
      .i_kind(kind[p]),
      .i_emu(state_reg.emu_lat),
      .i_mode(all_sel[2*p+1:2*p]),
      .o_ctl(ctl)
    );
    assign o_alt_sel[p] = ctl.alt_sel;
    assign o_out_en[p] = ctl.out_en;
    assign o_in_sel[p] = ctl.in_sel;
    assign o_pullup_en[p] = ctl.pullup_en;
    assign o_reserved_sel[p] = ctl.reserved;
  end
endmodule

/* File: shared/pfgh_pkg.sv */
// Package: register map, reset values and pin-mode encodings of the port F/G/H function select
package pfgh_pkg;
  localparam int PFGH_REG_W = 16;
  localparam int PFGH_PINS = 8;
  // Byte offsets on the register bus
  localparam logic [11:0] PFGH_OFF_F = 12'h000;
  localparam logic [11:0] PFGH_OFF_G = 12'h004;
  localparam logic [11:0] PFGH_OFF_H = 12'h008;
  // Power-on reset values, emulator select high / low
  localparam logic [15:0] PFGH_RST_EMU = 16'haaaa;
  localparam logic [15:0] PFGH_RST_F_LO = 16'h00aa;
  localparam logic [15:0] PFGH_RST_G_LO = 16'ha200;
  localparam logic [15:0] PFGH_RST_H_LO = 16'h8aaa;
  // Mode field codes
  localparam logic [1:0] PFGH_MD_ALT = 2'h0;
  localparam logic [1:0] PFGH_MD_OUT = 2'h1;
  localparam logic [1:0] PFGH_MD_PU_ON = 2'h2;
  localparam logic [1:0] PFGH_MD_PU_OFF = 2'h3;
  // Pin kinds that change how code 00 and 01 decode
  localparam logic [1:0] PFGH_KIND_PLAIN = 2'h0;
  localparam logic [1:0] PFGH_KIND_EMU = 2'h1;
  localparam logic [1:0] PFGH_KIND_NOALT = 2'h2;
  localparam logic [1:0] PFGH_KIND_OUT = 2'h3;
  // Decoded per-pin controls
  typedef struct packed {
    logic alt_sel;
    logic out_en;
    logic in_sel;
    logic pullup_en;
    logic reserved;
  } pfgh_pin_ctl_t;
  // AHB-Lite slave inputs
  typedef struct packed {
    logic hsel;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } pfgh_ahb_req_t;
endpackage

/* File: logic/pfgh_sync.sv */
// Two-flop synchroniser for a pin-level input
`timescale 1ns/1ps
module pfgh_sync (
  // Clock and control
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Level
  input wire logic i_async,
  output logic o_sync
);
  typedef struct packed {
    logic meta;
    logic sync;
  } pfgh_sync_st_t;
  pfgh_sync_st_t state_reg, state_next;

  // First flop feeds only the second
  always_comb begin
    state_next = state_reg;
    if (i_ce) begin
      state_next.meta = i_async;
      state_next.sync = state_reg.meta;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.sync;
endmodule

/* File: logic/pfgh_pin_decode.sv */
// Decode one two-bit pin mode field into mux select and pull-up controls
`timescale 1ns/1ps
module pfgh_pin_decode (
  // Pin kind and emulator level
  input wire logic [1:0] i_kind,
  input wire logic i_emu,
  // Field and result
  input wire logic [1:0] i_mode,
  output pfgh_pkg::pfgh_pin_ctl_t o_ctl
);
  import pfgh_pkg::*;

  // Unsupported codes yield a safe input-with-pull-up-off and raise reserved
  always_comb begin
    o_ctl = '0;
    case (i_mode)
      PFGH_MD_ALT: begin
        if (i_kind == PFGH_KIND_NOALT || (i_kind == PFGH_KIND_EMU && i_emu)) begin
          o_ctl.reserved = 1'b1;
          o_ctl.in_sel = 1'b1;
        end else begin
          o_ctl.alt_sel = 1'b1;
        end
      end
      PFGH_MD_OUT: begin
        if (i_kind == PFGH_KIND_OUT) begin
          o_ctl.out_en = 1'b1;
        end else begin
          o_ctl.reserved = 1'b1;
          o_ctl.in_sel = 1'b1;
        end
      end
      PFGH_MD_PU_ON: begin
        o_ctl.in_sel = 1'b1;
        o_ctl.pullup_en = 1'b1;
      end
      default: begin
        o_ctl.in_sel = 1'b1;
      end
    endcase
  end
endmodule

/* File: verif/pfgh_function_select_checker.sv */
// Assertions on the port F/G/H function select ports
`timescale 1ns/1ps
module pfgh_function_select_checker (
  // Clock, reset and bus
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire pfgh_pkg::pfgh_ahb_req_t i_ahb,
  // Responses and pin controls
  input wire logic [31:0] o_hrdata,
  input wire logic [23:0] o_alt_sel,
  input wire logic [23:0] o_out_en,
  input wire logic [23:0] o_in_sel,
  input wire logic [23:0] o_pullup_en
);
  import pfgh_pkg::*;
  logic take_w;
  logic take_r;
  // Transfers the slave accepts
  assign take_w = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1] & i_ahb.hwrite & i_ce;
  assign take_r = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1] & ~i_ahb.hwrite & i_ce;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_wr_f; take_w && i_ahb.haddr == PFGH_OFF_F; endsequence
  sequence s_rd_f; take_r && i_ahb.haddr == PFGH_OFF_F; endsequence
  sequence s_wr_h; take_w && i_ahb.haddr == PFGH_OFF_H; endsequence
  AST_RD_AFTER_WR: assert property (s_wr_f ##1 s_rd_f |=> o_hrdata == {16'h0000, $past(i_ahb.hwdata[15:0])})
    else $error("read after write differs");
  AST_RD_UPPER: assert property (take_r |=> o_hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  // Pin controls move only two edges after an accepted write, and never from reset-free side inputs
  AST_HOLD: assert property ((!$past(i_reset) && !$past(i_reset, 2) && !$past(i_reset, 3) && !$past(take_w, 2))
    |-> $stable(o_alt_sel) && $stable(o_pullup_en) && $stable(o_out_en))
    else $error("pin controls moved without a write");
  AST_F_DECODE: assert property (s_wr_f ##1 1'b1 |=> (o_alt_sel[7] == ($past(i_ahb.hwdata[15:14]) == 2'h0))
    && (o_pullup_en[0] == ($past(i_ahb.hwdata[1:0]) == 2'h2)))
    else $error("port F field decode wrong");
  AST_H7_OUT: assert property (s_wr_h ##1 1'b1 |=> o_out_en[23] == ($past(i_ahb.hwdata[15:14]) == 2'h1))
    else $error("port H pin 7 output wrong");
  AST_OUT_ONLY_H7: assert property (o_out_en[22:0] == 23'h0)
    else $error("output on a pin without output");
  AST_PU_IN: assert property ((o_pullup_en & ~o_in_sel) == 24'h0)
    else $error("pull-up without input");
  AST_ALT_IN: assert property ((o_alt_sel & o_in_sel) == 24'h0)
    else $error("alternate and input together");
  AST_G7_NO_ALT: assert property (!o_alt_sel[15])
    else $error("port G pin 7 alternate");
endmodule
bind pfgh_function_select pfgh_function_select_checker u_chk (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_ce(i_ce), .i_ahb(i_ahb), .o_hrdata(o_hrdata), .o_alt_sel(o_alt_sel), .o_out_en(o_out_en),
  .o_in_sel(o_in_sel), .o_pullup_en(o_pullup_en));

/* File: verif/pfgh_function_select_tb_top.sv */
// Self-checking bench for the port F/G/H function select
`timescale 1ns/1ps
module pfgh_function_select_tb_top;
  import pfgh_pkg::*;
  logic clk, rst, strap, mr, sb, rdy, resp;
  pfgh_ahb_req_t req, bus;
  logic [31:0] rdat, q;
  logic [23:0] alt, oe, ins, pu, rsv;
  int err_count, tests_run;
  logic [15:0] cur [3];
  localparam logic [11:0] OFFS [3] = '{PFGH_OFF_F, PFGH_OFF_G, PFGH_OFF_H};
  // The only slave drives hready
  always_comb begin
    bus = req;
    bus.hready = rdy;
  end
  pfgh_function_select u_pfgh_function_select (.i_core_clk(clk), .i_reset(rst), .i_ce(1'b1),
    .i_manual_reset(mr), .i_standby(sb), .i_emulator_select_input(strap), .i_ahb(bus),
    .o_hreadyout(rdy), .o_hresp(resp), .o_hrdata(rdat), .o_alt_sel(alt), .o_out_en(oe),
    .o_in_sel(ins), .o_pullup_en(pu), .o_reserved_sel(rsv));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic phase;
    do @(posedge clk); while (rdy !== 1'b1);
  endtask
  // Write, then read the same word back to back
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, a, 2'h2, 1'b1, 3'h2, 1'b0, 32'h0};
    phase();
    req.hwrite <= 1'b0;
    req.hwdata <= d;
    phase();
    req <= '0;
    phase();
    q = rdat;
  endtask
  task automatic rd(input logic [11:0] a);
    req <= '{1'b1, a, 2'h2, 1'b0, 3'h2, 1'b0, 32'h0};
    phase();
    req <= '0;
    phase();
    q = rdat;
  endtask
  // Expected controls from legal codes: reserved, pull-up, input, output, alternate
  function automatic logic [39:0] dec(input logic [15:0] v);
    dec = '0;
    for (int n = 0; n < 8; n++) begin
      dec[n] = v[2*n+:2] == 2'h0;
      dec[8+n] = v[2*n+:2] == 2'h1;
      dec[16+n] = v[2*n+1];
      dec[24+n] = v[2*n+:2] == 2'h2;
    end
  endfunction
  task automatic chk_port(input int p);
    rd(OFFS[p]);
    cmp({8'h0, q}, {24'h0, cur[p]});
    cmp({rsv[8*p+:8], pu[8*p+:8], ins[8*p+:8], oe[8*p+:8], alt[8*p+:8]}, dec(cur[p]));
    cmp({38'h0, rdy, resp}, 40'h2);
  endtask
  // Power-on reset with the strap at a given level
  task automatic sc_por(input logic s);
    @(posedge clk);
    strap <= s;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cur = s ? '{16'haaaa, 16'haaaa, 16'haaaa} : '{16'h00aa, 16'ha200, 16'h8aaa};
    for (int p = 0; p < 3; p++) chk_port(p);
  endtask
  // Each register set to all ones and then one other pattern, legal codes only; upper bus half must be dropped
  task automatic sc_rw;
    logic [15:0] tv [6] = '{16'hffff, 16'h0000, 16'hffff, 16'h8000, 16'hffff, 16'h7fff};
    for (int i = 0; i < 6; i++) begin
      wr_rd(OFFS[i/2], {16'hffff, tv[i]});
      cmp({8'h0, q}, {24'h0, tv[i]});
      cur[i/2] = tv[i];
      chk_port(i / 2);
    end
  endtask
  // Unmapped word reads zero; manual reset and standby keep contents
  task automatic sc_misc;
    wr_rd(12'h00c, 32'hffffffff);
    cmp({8'h0, q}, 40'h0);
    mr <= 1'b1;
    sb <= 1'b1;
    repeat (4) @(posedge clk);
    mr <= 1'b0;
    sb <= 1'b0;
    for (int p = 0; p < 3; p++) chk_port(p);
  endtask
  task automatic give_verdict;
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    err_count = 0;
    tests_run = 0;
    rst = 1'b1;
    strap = 1'b1;
    mr = 1'b0;
    sb = 1'b0;
    req = '0;
    sc_por(1'b1);
    sc_misc;
    sc_por(1'b0);
    sc_rw;
    sc_misc;
    give_verdict;
  end
  // Watchdog well beyond the fewer than a hundred cycles the run needs
  initial begin
    #20000;
    err_count++;
    give_verdict;
  end
endmodule
